// [rtl/cond_pin_pkg.sv]
// Purpose: shared constants, types and register map of the condition pin,
//          interrupt request and timer expiry block
// Assumes: 32-bit register port, word-aligned byte addresses
// Notes:   all offsets, field positions and reset values live here

package cond_pin_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int PIN_CNT = 4;   // condition pins and request inputs
    localparam int ADDR_W = 8;    // register port address width
    localparam int DATA_W = 32;   // register port data width

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] DIR_OFS = 8'h00;     // pin direction, 1 = output
    localparam logic [7:0] OUT_OFS = 8'h04;     // pin output value
    localparam logic [7:0] PIN_OFS = 8'h08;     // synchronised pin level, ro
    localparam logic [7:0] IEN_OFS = 8'h0C;     // request input enable
    localparam logic [7:0] IMODE_OFS = 8'h10;   // 1 = edge, 0 = level
    localparam logic [7:0] STAT_OFS = 8'h14;    // sticky events, w1c
    localparam logic [7:0] MASK_OFS = 8'h18;    // event mask, 1 = pass
    localparam logic [7:0] STRAP_OFS = 8'h1C;   // latched strap level, ro

    // ************************************************************
    // status / mask field positions
    // ************************************************************
    localparam int STAT_IRQ_LSB = 0;   // bits 3:0 request events
    localparam int STAT_TMR_BIT = 4;   // timer 0 expiry event
    localparam int STAT_W = 5;         // used status width

    // ************************************************************
    // strap register field positions
    // ************************************************************
    localparam int STRAP_LVL_BIT = 0;    // latched expiry pin level
    localparam int STRAP_BOOT_BIT = 1;   // request-boot option selected

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] DIR_RST = 4'h0;      // all pins input
    localparam logic [3:0] OUT_RST = 4'h0;      // output value cleared
    localparam logic [3:0] IEN_RST = 4'h0;      // requests disabled
    localparam logic [3:0] IMODE_RST = 4'h0;    // level sensitive
    localparam logic [4:0] STAT_RST = 5'h00;    // no events
    localparam logic [4:0] MASK_RST = 5'h00;    // all masked
    localparam logic STRAP_BOOT_LVL = 1'b1;     // strap level for irq boot

    // ************************************************************
    // timing counts
    // ************************************************************
    localparam int STRAP_HOLD_CYC = 2;   // cycles the pin is sampled
    localparam int SYNC_STAGES = 2;      // synchroniser depth

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // byte address
        logic [DATA_W-1:0] wdata;  // write data
        logic wr;                  // write strobe
        logic rd;                  // read strobe
    } reg_req_t;

    typedef struct packed {
        logic [3:0] o;    // pin output value
        logic [3:0] oe_n; // pin output enable, low = driving
    } pin_drive_t;

    // strap sequencing states
    typedef enum logic [1:0] {
        STRAP_SAMPLE,
        STRAP_BOOT_WAIT,
        STRAP_RUN
    } strap_state_t;

endpackage

// [rtl/sync_two_stage.sv]
// Purpose: two-flip-flop synchroniser for a vector of asynchronous levels
// Assumes: each bit is independent; no bus coherence is needed
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ps

module sync_two_stage #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ************************************************************
    // synchroniser stages
    // ************************************************************
    logic [WIDTH-1:0] meta_r;   // metastable stage, read only by next stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] stab_r;   // settled stage
    logic [WIDTH-1:0] stab_nxt;

    // next values: shift one stage per clock
    always_comb
    begin
        meta_nxt = async_in;
        stab_nxt = meta_r;
    end

    // register both stages
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_r <= RST_VAL;
            stab_r <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            stab_r <= stab_nxt;
        end
    end

    assign sync_out = stab_r;

endmodule // sync_two_stage

// [rtl/cond_pin_block.sv]
// Purpose: condition pins, external request inputs and timer 0 expiry pin
// Assumes: pins asynchronous; core strobes synchronous to clk
// Notes:   registers on a plain strobe port, read data one cycle later
//
// Overview of operation
// - each condition pin direction set independently
// - reset leaves all condition pins as inputs
// - synchronised pin levels feed sequencer conditions
// - enabled low request raises core interrupt
// - per request input edge or level choice
// - requests disabled after reset unless boot strap
// - one expiry pin pulse per timer expiry after strap handover
// - expiry pin latched as strap in the first two cycles after reset
//
// The implementer's own choices: the address map and the strobed register port.

`timescale 1ns/1ps

module cond_pin_block
    import cond_pin_pkg::*;
#(
    parameter int NPIN = PIN_CNT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NPIN-1:0] condition_io_pins_i,
    output logic [NPIN-1:0] condition_io_pins_o,
    output logic [NPIN-1:0] condition_io_pins_oe_n,
    input wire logic [NPIN-1:0] external_interrupt_request_n,
    input wire logic boot_vectors_ready,
    input wire logic timer_zero_expired,
    input wire logic timer_zero_expiry_pulse_i,
    output logic timer_zero_expiry_pulse,
    output logic timer_zero_expiry_pulse_oe_n,
    output logic [NPIN-1:0] seq_condition,
    output logic [NPIN-1:0] core_irq,
    output logic irq
);

    // ************************************************************
    // local declarations
    // ************************************************************
    reg_req_t req;                  // bundled register request
    pin_drive_t drv;                // bundled pin drive
    logic [NPIN-1:0] pin_sync;      // synchronised condition pins
    logic [NPIN-1:0] req_sync_n;    // synchronised request inputs
    logic [NPIN-1:0] req_prev_n_r;  // previous request level for edges
    logic [NPIN-1:0] req_prev_n_nxt;
    logic [3:0] dir_r;              // 1 = pin driven
    logic [3:0] dir_nxt;
    logic [3:0] out_r;              // value driven on output pins
    logic [3:0] out_nxt;
    logic [3:0] ien_r;              // request enables
    logic [3:0] ien_nxt;
    logic [3:0] imode_r;            // 1 = edge triggered
    logic [3:0] imode_nxt;
    logic [4:0] stat_r;             // sticky events
    logic [4:0] stat_nxt;
    logic [4:0] mask_r;             // event mask
    logic [4:0] mask_nxt;
    logic [NPIN-1:0] core_irq_r;    // request lines to the core
    logic [NPIN-1:0] core_irq_nxt;
    logic [NPIN-1:0] cond_r;        // sequencer conditions
    logic [NPIN-1:0] cond_nxt;
    logic irq_r;                    // summary interrupt
    logic irq_nxt;
    logic [DATA_W-1:0] rdata_r;     // read data
    logic [DATA_W-1:0] rdata_nxt;
    logic [NPIN-1:0] pin_o_r;       // pin output register
    logic [NPIN-1:0] pin_oe_n_r;    // pin enable register
    strap_state_t st_r;             // strap sequencing state
    strap_state_t st_nxt;
    logic strap_lvl_r;              // latched expiry pin level
    logic strap_lvl_nxt;
    logic [1:0] hold_r;             // strap sample counter
    logic [1:0] hold_nxt;
    logic tmr_o_r;                  // expiry pin drive
    logic tmr_o_nxt;
    logic tmr_oe_n_r;               // expiry pin enable, high while strap
    logic tmr_oe_n_nxt;
    logic [NPIN-1:0] req_event;     // detected request per input

    // write decode used by every writable register
    function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    // pad a narrow field into a read word
    function automatic logic [DATA_W-1:0] pad(input logic [4:0] v);
        pad = {{(DATA_W-5){1'b0}}, v};
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    sync_two_stage #(.WIDTH(NPIN), .RST_VAL('1)) u_pin_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(condition_io_pins_i),
        .sync_out(pin_sync)
    );

    sync_two_stage #(.WIDTH(NPIN), .RST_VAL('1)) u_req_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(external_interrupt_request_n),
        .sync_out(req_sync_n)
    );

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // ************************************************************
    // strap sampling and boot enable
    // ************************************************************
    // sample the expiry pin while undriven, then hand it to the timer;
    // pin is not driven until sampling is over so the strap is not fought
    always_comb
    begin
        st_nxt = st_r;
        strap_lvl_nxt = strap_lvl_r;
        hold_nxt = hold_r;
        tmr_oe_n_nxt = tmr_oe_n_r;
        case (st_r)
            STRAP_SAMPLE:
            begin
                strap_lvl_nxt = timer_zero_expiry_pulse_i;
                hold_nxt = hold_r + 2'd1;
                if (hold_r == 2'(STRAP_HOLD_CYC - 1))
                begin
                    tmr_oe_n_nxt = 1'b0;
                    st_nxt = (timer_zero_expiry_pulse_i == STRAP_BOOT_LVL)
                        ? STRAP_BOOT_WAIT : STRAP_RUN;
                end
            end
            STRAP_BOOT_WAIT:
            begin
                // vectors must be ready before boot requests are armed
                if (boot_vectors_ready)
                    st_nxt = STRAP_RUN;
            end
            STRAP_RUN:
                st_nxt = STRAP_RUN;
            default:
                st_nxt = STRAP_SAMPLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= STRAP_SAMPLE;
            strap_lvl_r <= 1'b0;
            hold_r <= 2'd0;
            tmr_oe_n_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            strap_lvl_r <= strap_lvl_nxt;
            hold_r <= hold_nxt;
            tmr_oe_n_r <= tmr_oe_n_nxt;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_comb
    begin
        dir_nxt = dir_r;
        out_nxt = out_r;
        ien_nxt = ien_r;
        imode_nxt = imode_r;
        mask_nxt = mask_r;
        if (hit(req, DIR_OFS))
            dir_nxt = req.wdata[3:0];
        if (hit(req, OUT_OFS))
            out_nxt = req.wdata[3:0];
        if (hit(req, IMODE_OFS))
            imode_nxt = req.wdata[3:0];
        if (hit(req, MASK_OFS))
            mask_nxt = req.wdata[4:0];
        // boot strap arms all requests once the vectors are ready
        if (st_r == STRAP_BOOT_WAIT && boot_vectors_ready)
            ien_nxt = 4'hF;
        if (hit(req, IEN_OFS))
            ien_nxt = req.wdata[3:0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dir_r <= DIR_RST;
            out_r <= OUT_RST;
            ien_r <= IEN_RST;
            imode_r <= IMODE_RST;
            mask_r <= MASK_RST;
        end
        else
        begin
            dir_r <= dir_nxt;
            out_r <= out_nxt;
            ien_r <= ien_nxt;
            imode_r <= imode_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ************************************************************
    // request detection, events and outputs
    // ************************************************************
    // edge: synchronised falling edge; level: low while sampled
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            if (imode_r[i])
                req_event[i] = ien_r[i] && req_prev_n_r[i]
                    && !req_sync_n[i];
            else
                req_event[i] = ien_r[i] && !req_sync_n[i];
        end
    end

    always_comb
    begin
        req_prev_n_nxt = req_sync_n;
        core_irq_nxt = req_event;
        cond_nxt = pin_sync;
        // one high cycle per expiry, only after strap handover
        tmr_o_nxt = timer_zero_expired && !tmr_oe_n_r;
        // set wins over a write-one clear in the same cycle
        stat_nxt = stat_r;
        if (hit(req, STAT_OFS))
            stat_nxt = stat_r & ~req.wdata[4:0];
        stat_nxt[3:0] = stat_nxt[3:0] | req_event;
        stat_nxt[STAT_TMR_BIT] = stat_nxt[STAT_TMR_BIT] | tmr_o_nxt;
        irq_nxt = |(stat_nxt & mask_r);
        drv.o = out_r;
        drv.oe_n = ~dir_r;
        rdata_nxt = '0;
        if (req.rd)
        begin
            case (req.addr)
                DIR_OFS: rdata_nxt = pad({1'b0, dir_r});
                OUT_OFS: rdata_nxt = pad({1'b0, out_r});
                PIN_OFS: rdata_nxt = pad({1'b0, pin_sync});
                IEN_OFS: rdata_nxt = pad({1'b0, ien_r});
                IMODE_OFS: rdata_nxt = pad({1'b0, imode_r});
                STAT_OFS: rdata_nxt = pad(stat_r);
                MASK_OFS: rdata_nxt = pad(mask_r);
                STRAP_OFS: rdata_nxt = pad({3'b000,
                    st_r == STRAP_BOOT_WAIT || strap_lvl_r == STRAP_BOOT_LVL,
                    strap_lvl_r});
                default: rdata_nxt = '0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_prev_n_r <= '1;
            core_irq_r <= '0;
            cond_r <= '0;
            tmr_o_r <= 1'b0;
            stat_r <= STAT_RST;
            irq_r <= 1'b0;
            rdata_r <= '0;
            pin_o_r <= OUT_RST;
            pin_oe_n_r <= ~DIR_RST;
        end
        else
        begin
            req_prev_n_r <= req_prev_n_nxt;
            core_irq_r <= core_irq_nxt;
            cond_r <= cond_nxt;
            tmr_o_r <= tmr_o_nxt;
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            pin_o_r <= drv.o;
            pin_oe_n_r <= drv.oe_n;
        end
    end

    assign reg_rdata = rdata_r;
    assign condition_io_pins_o = pin_o_r;
    assign condition_io_pins_oe_n = pin_oe_n_r;
    assign timer_zero_expiry_pulse = tmr_o_r;
    assign timer_zero_expiry_pulse_oe_n = tmr_oe_n_r;
    assign seq_condition = cond_r;
    assign core_irq = core_irq_r;
    assign irq = irq_r;

endmodule // cond_pin_block

// [verif/pin_partner.sv]
// Purpose: far-side model of the condition and expiry pin wires
// Assumes: pull-ups on condition pins, strap driven while pin released
// Notes: design drive wins; bench keeps its own drive off driven pins
`timescale 1ns/1ps

module pin_partner
    import cond_pin_pkg::*;
(
    input wire logic [PIN_CNT-1:0] drv_o,
    input wire logic [PIN_CNT-1:0] drv_oe_n,
    input wire logic [PIN_CNT-1:0] ext_val,
    input wire logic [PIN_CNT-1:0] ext_en,
    input wire logic tmr_o,
    input wire logic tmr_oe_n,
    input wire logic strap_lvl,
    output logic [PIN_CNT-1:0] pin_lvl,
    output logic tmr_lvl
);
    // wire level: design drive, else external drive, else pull-up
    assign pin_lvl = (~drv_oe_n & drv_o) | (drv_oe_n & ext_en & ext_val)
        | (drv_oe_n & ~ext_en);
    // strap level stands on the pin until the block takes it over
    assign tmr_lvl = tmr_oe_n ? strap_lvl : tmr_o;
endmodule // pin_partner

// [verif/cond_pin_block_assertions.sv]
// Purpose: port-level checks of the condition pin block
// Assumes: one clock domain, async active-high reset
// Notes: helper logic only counts edges, latches the strap level and tracks enable writes and boot-path arming
`timescale 1ns/1ps

module cond_pin_block_assertions
    import cond_pin_pkg::*;
#(
    parameter int NPIN = 4
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [NPIN-1:0] condition_io_pins_i,
    input wire logic [NPIN-1:0] condition_io_pins_o,
    input wire logic [NPIN-1:0] condition_io_pins_oe_n,
    input wire logic [NPIN-1:0] external_interrupt_request_n,
    input wire logic boot_vectors_ready,
    input wire logic timer_zero_expired,
    input wire logic timer_zero_expiry_pulse_i,
    input wire logic timer_zero_expiry_pulse,
    input wire logic timer_zero_expiry_pulse_oe_n,
    input wire logic [NPIN-1:0] seq_condition,
    input wire logic [NPIN-1:0] core_irq
);
    // ****
    // helper state
    // ****
    logic [2:0] rel_r, rel_nxt; // edges since release, saturating
    logic quiet_r, quiet_nxt; // no enable possible yet
    logic lvl_r, lvl_nxt; // strap level at the decision edge

    // next values; quiet drops early, so it never over-claims
    always_comb
    begin
        rel_nxt = (rel_r == 3'h7) ? rel_r : rel_r + 3'h1;
        lvl_nxt = (rel_r == 3'h1) ? timer_zero_expiry_pulse_i : lvl_r;
        quiet_nxt = quiet_r;
        if (reg_wr && reg_addr == IEN_OFS)
            quiet_nxt = 1'b0; // software enable
        if (lvl_r && boot_vectors_ready)
            quiet_nxt = 1'b0; // boot path arms enables
    end

    // registers only
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rel_r <= 3'h0;
            quiet_r <= 1'b1;
            lvl_r <= 1'b0;
        end
        else
        begin
            rel_r <= rel_nxt;
            quiet_r <= quiet_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // ****
    // properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_dir_wr;
        reg_wr && reg_addr == DIR_OFS;
    endsequence
    sequence s_out_wr;
        reg_wr && reg_addr == OUT_OFS;
    endsequence

    a_dir_drive: assert property (s_dir_wr |-> ##2
        condition_io_pins_oe_n == ~$past(reg_wdata[NPIN-1:0], 2))
        else $error("pin enable does not follow direction");
    a_out_drive: assert property (s_out_wr |-> ##2
        condition_io_pins_o == $past(reg_wdata[NPIN-1:0], 2))
        else $error("pin value does not follow output");
    a_reset_inputs: assert property (rel_r < 3'h2 |->
        condition_io_pins_oe_n == '1 && core_irq == '0)
        else $error("pins driven right after reset");
    a_cond_sync: assert property (rel_r > 3'h3 |->
        seq_condition == $past(condition_io_pins_i, 3))
        else $error("condition level late or wrong");
    a_req_cause: assert property (rel_r > 3'h3 |->
        (core_irq & $past(external_interrupt_request_n, 3)) == '0)
        else $error("interrupt without low request");
    a_quiet_reset: assert property (quiet_r |-> core_irq == '0)
        else $error("interrupt before any enable");
    a_tmr_cause: assert property (timer_zero_expiry_pulse |->
        $past(timer_zero_expired))
        else $error("expiry pulse without expiry");
    a_tmr_follow: assert property (timer_zero_expired &&
        !timer_zero_expiry_pulse_oe_n |=> timer_zero_expiry_pulse)
        else $error("expiry pulse missing");
    a_strap_hold: assert property (rel_r < 3'h2 |->
        timer_zero_expiry_pulse_oe_n)
        else $error("expiry pin driven during strap");
    a_strap_drive: assert property (rel_r > 3'h1 |->
        !timer_zero_expiry_pulse_oe_n)
        else $error("expiry pin not taken over");
endmodule // cond_pin_block_assertions

bind cond_pin_block cond_pin_block_assertions #(.NPIN(NPIN)) chk_i (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .condition_io_pins_i, .condition_io_pins_o, .condition_io_pins_oe_n,
    .external_interrupt_request_n, .boot_vectors_ready,
    .timer_zero_expired, .timer_zero_expiry_pulse_i,
    .timer_zero_expiry_pulse, .timer_zero_expiry_pulse_oe_n,
    .seq_condition, .core_irq
);

// [verif/tb.sv]
// Purpose: self-checking bench of the condition pin block
// Assumes: 200 MHz clock, register port with one-cycle read data
// Notes: each scenario task drives and judges on its own
`timescale 1ns/1ps

module tb;
    import cond_pin_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0] pins_i, pins_o, pins_oe_n, seq_condition, core_irq;
    logic [3:0] ext_val = 4'h0; // bench drive on input pins
    logic [3:0] ext_en = 4'h0;
    logic [3:0] req_n = 4'hF; // requests idle high
    logic boot_rdy = 1'b0;
    logic tmr_exp = 1'b0;
    logic strap_lvl = 1'b0;
    logic tmr_i, tmr_o, tmr_oe_n, irq;
    int num_errors = 0;
    int checked = 0;

    // ****
    // block, partner and clock
    // ****
    cond_pin_block cond_pin_block_i (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .condition_io_pins_i(pins_i), .condition_io_pins_o(pins_o),
        .condition_io_pins_oe_n(pins_oe_n),
        .external_interrupt_request_n(req_n), .boot_vectors_ready(boot_rdy),
        .timer_zero_expired(tmr_exp), .timer_zero_expiry_pulse_i(tmr_i),
        .timer_zero_expiry_pulse(tmr_o),
        .timer_zero_expiry_pulse_oe_n(tmr_oe_n),
        .seq_condition(seq_condition), .core_irq(core_irq), .irq(irq));
    pin_partner pin_partner_i (.drv_o(pins_o), .drv_oe_n(pins_oe_n),
        .ext_val(ext_val), .ext_en(ext_en), .tmr_o(tmr_o),
        .tmr_oe_n(tmr_oe_n), .strap_lvl(strap_lvl), .pin_lvl(pins_i),
        .tmr_lvl(tmr_i));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // ****
    // shared tasks
    // ****
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // wait n edges, then step past them so outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    // strap level is presented for the whole reset
    task automatic do_reset(input logic lvl);
        sys_rst <= 1'b1;
        strap_lvl <= lvl;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(4);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset_vals();
        check("pin enables", 32'(4'hF), 32'(pins_oe_n));
        check("pin levels", 32'(4'hF), 32'(seq_condition));
        check("expiry enable", 32'h0, 32'(tmr_oe_n));
        rd_chk(DIR_OFS, 32'h0, "dir");
        rd_chk(OUT_OFS, 32'h0, "out");
        rd_chk(IEN_OFS, 32'h0, "ien");
        rd_chk(IMODE_OFS, 32'h0, "imode");
        rd_chk(STAT_OFS, 32'h0, "stat");
        rd_chk(MASK_OFS, 32'h0, "mask");
        rd_chk(STRAP_OFS, 32'h0, "strap");
        rd_chk(8'h20, 32'h0, "unmapped");
    endtask

    // pins 0 and 2 out, 1 and 3 driven from outside
    task automatic t_direction();
        @(posedge clk);
        ext_en <= 4'hA;
        ext_val <= 4'h2;
        wr(OUT_OFS, 32'h5);
        wr(DIR_OFS, 32'h5);
        cyc(5);
        check("pin enables", 32'(4'hA), 32'(pins_oe_n));
        check("pin drive", 32'(4'h5), 32'(pins_o));
        check("seq cond", 32'(4'h7), 32'(seq_condition));
        rd_chk(PIN_OFS, 32'h7, "pin reg");
        wr(DIR_OFS, 32'h0);
        ext_en <= 4'h0;
        cyc(5);
        check("pins released", 32'(4'hF), 32'(pins_oe_n));
    endtask

    // bit 0 enabled in level mode, bit 1 low but disabled
    task automatic t_level();
        wr(MASK_OFS, 32'h1F);
        wr(IEN_OFS, 32'h1);
        @(posedge clk);
        req_n <= 4'hC;
        cyc(2);
        check("irq early", 32'h0, 32'(core_irq));
        cyc(1);
        check("irq level", 32'h1, 32'(core_irq));
        cyc(5);
        check("irq held", 32'h1, 32'(core_irq));
        check("summary", 32'h1, 32'(irq));
        rd_chk(STAT_OFS, 32'h1, "stat level");
        @(posedge clk);
        req_n <= 4'hF;
        cyc(5);
        check("irq gone", 32'h0, 32'(core_irq));
        wr(STAT_OFS, 32'h1F);
        rd_chk(STAT_OFS, 32'h0, "stat cleared");
        check("summary off", 32'h0, 32'(irq));
    endtask

    // bit 1 in edge mode gives one pulse while held low
    task automatic t_edge();
        wr(IMODE_OFS, 32'h2);
        wr(IEN_OFS, 32'h2);
        wr(MASK_OFS, 32'h0);
        @(posedge clk);
        req_n <= 4'hD;
        cyc(3);
        check("edge pulse", 32'h2, 32'(core_irq));
        cyc(1);
        check("edge once", 32'h0, 32'(core_irq));
        cyc(3);
        check("masked", 32'h0, 32'(irq));
        rd_chk(STAT_OFS, 32'h2, "stat edge");
        wr(MASK_OFS, 32'h2);
        cyc(2);
        check("unmasked", 32'h1, 32'(irq));
        wr(STAT_OFS, 32'h2);
        req_n <= 4'hF;
        cyc(2);
        check("edge cleared", 32'h0, 32'(irq));
    endtask

    task automatic t_timer();
        wr(MASK_OFS, 32'h10);
        @(posedge clk);
        tmr_exp <= 1'b1;
        @(posedge clk);
        tmr_exp <= 1'b0;
        #1;
        check("expiry pulse", 32'h1, 32'(tmr_o));
        cyc(1);
        check("pulse ends", 32'h0, 32'(tmr_o));
        check("timer irq", 32'h1, 32'(irq));
        rd_chk(STAT_OFS, 32'h10, "stat timer");
        wr(STAT_OFS, 32'h10);
    endtask

    // mid-run reset with the boot strap set
    task automatic t_boot();
        @(posedge clk);
        do_reset(1'b1);
        rd_chk(STRAP_OFS, 32'h3, "strap boot");
        rd_chk(IEN_OFS, 32'h0, "ien wait");
        @(posedge clk);
        boot_rdy <= 1'b1;
        cyc(2);
        rd_chk(IEN_OFS, 32'hF, "ien boot");
    endtask

    // ****
    // verdict, main sequence, watchdog
    // ****
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        do_reset(1'b0);
        t_reset_vals();
        t_direction();
        t_level();
        t_edge();
        t_timer();
        t_boot();
        report_and_stop();
    end

    // scenarios need about 135 cycles; this is far beyond
    initial
    begin
        #50000;
        num_errors++;
        report_and_stop();
    end
endmodule // tb
